// >>> hdl/clock_source_map.vh
// Constants for the system clock source selection and start-up sequencing
`ifndef CLOCK_SOURCE_MAP_VH
`define CLOCK_SOURCE_MAP_VH

// ==========================================
// Selection codes as stored (1 = unprogrammed)
`define SEL_EXT_CLOCK 4'h0
`define SEL_PLL_EXTCLK 4'h1
`define SEL_RC_OSC 4'h2
`define SEL_PLL_RC 4'h3
`define SEL_EXTOSC_BOTH 4'h4
`define SEL_PLL_EXTOSC 4'h5
`define SEL_XTAL_MSB 3

// ==========================================
// Source encodings used on the mux outputs
`define SRC_EXT_CLOCK 2'h0
`define SRC_RC_OSC 2'h1
`define SRC_EXT_OSC 2'h2
`define SRC_PLL_DIV4 2'h3

// ==========================================
// Factory defaults (stored bit patterns)
`define DEFAULT_SOURCE_SELECT 4'h2
`define DEFAULT_STARTUP_SELECT 2'h2
`define DEFAULT_DIV8_STORED 1'h0

// ==========================================
// Timing: watchdog oscillator time-outs, start-up and switch delays, PLL divider, counter width
`define WDT_TIMEOUT_CYCLES 15'h2000
`define WDT_TIMEOUT_MS_5V 65
`define WDT_TIMEOUT_MS_3V 69
`define WDT_SHORT_CYCLES 15'h0200
`define RESET_EXTRA_CK 15'h000e
`define RC_START_CK 15'h0006
`define RES_START_SHORT_CK 15'h0102
`define RES_START_LONG_CK 15'h0400
`define XTAL_START_CK 15'h4000
`define SWITCH_GAP_CK 15'h0002
`define PLL_DIV 4
`define COUNT_W 15

`endif

// >>> hdl/clock_select_decode.v
// Decoder from the stored selection field to system clock and PLL input sources
`timescale 1ns/1ps
`include "clock_source_map.vh"

module clock_select_decode (
  input wire [3:0] i_sel,
  input wire i_later_variant,
  output reg [1:0] o_sys_src,
  output reg [1:0] o_pll_src,
  output reg o_invalid
);

  always @* begin
    o_sys_src = `SRC_RC_OSC;
    o_pll_src = `SRC_RC_OSC;
    o_invalid = 1'b0;
    if (i_sel[`SEL_XTAL_MSB]) begin
      o_sys_src = `SRC_EXT_OSC;
      o_pll_src = `SRC_RC_OSC;
    end else if (!i_later_variant) begin
      case (i_sel)
        `SEL_PLL_RC: o_sys_src = `SRC_PLL_DIV4;
        `SEL_RC_OSC: o_sys_src = `SRC_RC_OSC;
        `SEL_EXT_CLOCK: o_sys_src = `SRC_EXT_CLOCK;
        default: o_invalid = 1'b1;
      endcase
    end else begin
      case (i_sel)
        `SEL_EXTOSC_BOTH: begin
          o_sys_src = `SRC_EXT_OSC;
          o_pll_src = `SRC_EXT_OSC;
        end
        `SEL_PLL_EXTOSC: begin
          o_sys_src = `SRC_PLL_DIV4;
          o_pll_src = `SRC_EXT_OSC;
        end
        `SEL_PLL_RC: o_sys_src = `SRC_PLL_DIV4;
        `SEL_RC_OSC: o_sys_src = `SRC_RC_OSC;
        `SEL_PLL_EXTCLK: begin
          o_sys_src = `SRC_PLL_DIV4;
          o_pll_src = `SRC_EXT_CLOCK;
        end
        `SEL_EXT_CLOCK: o_sys_src = `SRC_EXT_CLOCK;
        default: o_invalid = 1'b1;
      endcase
    end
  end

endmodule

// >>> hdl/delay_counter.v
// Loadable down-counter that advances on a tick and flags completion
`timescale 1ns/1ps
`include "clock_source_map.vh"

module delay_counter (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_load,
  input wire [`COUNT_W-1:0] i_count,
  input wire i_tick,
  output reg o_done
);

  reg [`COUNT_W-1:0] remain;

  always @(posedge i_clk) begin
    if (i_rst) begin
      remain <= {`COUNT_W{1'b0}};
      o_done <= 1'b0;
    end else if (i_ce) begin
      if (i_load) begin
        remain <= i_count;
        o_done <= (i_count == {`COUNT_W{1'b0}});
      end else if (i_tick && remain != {`COUNT_W{1'b0}}) begin
        remain <= remain - {{(`COUNT_W-1){1'b0}}, 1'b1};
        o_done <= (remain == {{(`COUNT_W-1){1'b0}}, 1'b1});
      end
    end
  end

endmodule

// >>> hdl/clock_source_control.v
// System clock source selection, domain enables and start-up sequencing
//
// Functional notes
// - Earlier variant: 1xxx crystal, 0011 PLL/4, 0010 RC, 0000 ext clock, the rest reserved.
// - Later variant: 1xxx ext oscillator with RC-fed PLL, 0100 ext oscillator for both.
// - Later variant: 0101 is PLL/4 from a crystal-fed PLL, 0011 PLL/4 from an RC-fed PLL.
// - Later variant: 0001 PLL/4 from ext clock, 0010 RC for both, 0000 ext clock, RC-fed PLL.
// - Each stored selection bit reads one as unprogrammed and zero as programmed.
// - The PLL gives 64 or 32 MHz to the power stage controllers and a 16 MHz core clock.
// - After power-down or power-save, start-up is timed on the selected source before running.
// - After reset an extra stabilisation delay is counted on watchdog oscillator cycles.
// - One reset time-out is 8192 watchdog oscillator cycles.
// - Clocks of unused modules can be stopped through sleep requests.
// - Stopping the core clock stops the core register file, status and stack.
// - The peripheral clock feeds timers and serial units; async interrupts still wake it.
// - The program memory clock runs whenever the core clock runs.
// - The converter clock keeps running while core and peripheral clocks are stopped.
// - Factory default is RC oscillator, start-up select 10, divide-by-eight programmed.
`timescale 1ns/1ps
`include "clock_source_map.vh"

module clock_source_control #(
  parameter [`COUNT_W-1:0] WDT_TIMEOUT = `WDT_TIMEOUT_CYCLES,
  parameter [`COUNT_W-1:0] XTAL_START = `XTAL_START_CK
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_later_variant,
  input wire i_fuse_programmed,
  input wire [3:0] i_clock_source_select_field,
  input wire [1:0] i_startup_time_select,
  input wire i_divide_by_eight_option,
  input wire i_fast_64,
  input wire i_wdt_tick,
  input wire i_src_tick,
  input wire i_ext_clock_ready,
  input wire i_rc_ready,
  input wire i_ext_osc_ready,
  input wire i_pll_lock,
  input wire i_power_down,
  input wire i_stop_core,
  input wire i_stop_peripheral,
  input wire i_stop_converter,
  input wire i_async_wake,
  output reg [1:0] o_sys_src,
  output reg [1:0] o_pll_src,
  output reg o_pll_enable,
  output reg o_fast_64,
  output reg o_div8_active,
  output reg o_cfg_invalid,
  output reg o_core_clock_en,
  output reg o_peripheral_clock_en,
  output reg o_program_memory_clock_en,
  output reg o_converter_clock_en,
  output reg o_fast_multiplied_clock_en,
  output reg o_cpu_run
);

  // ==========================================
  // Sequencer states
  localparam ST_LATCH = 3'h0;
  localparam ST_RST_DLY = 3'h1;
  localparam ST_SWITCH = 3'h2;
  localparam ST_START = 3'h3;
  localparam ST_RUN = 3'h4;
  localparam ST_SLEEP = 3'h5;
  localparam ST_FAULT = 3'h6;

  localparam [`COUNT_W-1:0] CNT_WDT_LONG = WDT_TIMEOUT;
  localparam [`COUNT_W-1:0] CNT_WDT_SHORT = `WDT_SHORT_CYCLES;
  localparam [`COUNT_W-1:0] CNT_EXTRA = `RESET_EXTRA_CK;
  localparam [`COUNT_W-1:0] CNT_RC = `RC_START_CK;
  localparam [`COUNT_W-1:0] CNT_RES_S = `RES_START_SHORT_CK;
  localparam [`COUNT_W-1:0] CNT_RES_L = `RES_START_LONG_CK;
  localparam [`COUNT_W-1:0] CNT_XTAL = XTAL_START;
  localparam [`COUNT_W-1:0] CNT_GAP = `SWITCH_GAP_CK;
  localparam [`COUNT_W-1:0] CNT_ZERO = {`COUNT_W{1'b0}};

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] sel;
  reg [1:0] startup_time_select;
  reg div8_stored;
  reg wdt_load;
  reg src_load;
  reg [`COUNT_W-1:0] wdt_count;
  reg [`COUNT_W-1:0] src_count;
  reg src_ready;
  reg from_reset;
  reg next_run;
  reg next_core_en;
  reg next_peripheral_en;
  reg next_converter_en;
  reg next_pll_enable;
  reg next_pll_clock_en;

  wire [1:0] dec_sys;
  wire [1:0] dec_pll;
  wire dec_invalid;
  wire wdt_done;
  wire src_done;
  wire pll_used;
  wire take_fuses;
  wire [1:0] load_sut;
  wire [`COUNT_W-1:0] src_load_count;

  // ==========================================
  // Selection decode
  clock_select_decode u_decode (
    .i_sel(sel),
    .i_later_variant(i_later_variant),
    .o_sys_src(dec_sys),
    .o_pll_src(dec_pll),
    .o_invalid(dec_invalid)
  );

  assign pll_used = (dec_sys == `SRC_PLL_DIV4) | (dec_pll != `SRC_RC_OSC) | i_fast_64;

  // Fuse bits are taken on the first enabled edge after reset, if the fuses are programmed
  assign take_fuses = i_ce && state == ST_LATCH && i_fuse_programmed;
  // The reset delay loads on that same edge, so it must see the incoming start-up bits
  assign load_sut = take_fuses ? i_startup_time_select : startup_time_select;
  // Switch gap on the way into the switch state, start-up count otherwise
  assign src_load_count = (next_state == ST_SWITCH) ? CNT_GAP : src_count;

  // ==========================================
  // Configuration capture, taken after reset release rather than under reset
  always @(posedge i_clk) begin
    if (i_rst) begin
      sel <= `DEFAULT_SOURCE_SELECT;
      startup_time_select <= `DEFAULT_STARTUP_SELECT;
      div8_stored <= `DEFAULT_DIV8_STORED;
    end else if (take_fuses) begin
      sel <= i_clock_source_select_field;
      startup_time_select <= i_startup_time_select;
      div8_stored <= i_divide_by_eight_option;
    end
  end

  // ==========================================
  // Delay amounts
  always @* begin
    wdt_count = CNT_EXTRA;
    case (load_sut)
      2'h0: wdt_count = CNT_EXTRA;
      2'h1: wdt_count = CNT_WDT_SHORT;
      2'h2: wdt_count = CNT_WDT_LONG;
      default: wdt_count = CNT_WDT_SHORT;
    endcase
  end

  // Crystal start-up follows the low selection bit and start-up select
  always @* begin
    src_count = CNT_RC;
    if (sel[`SEL_XTAL_MSB] || dec_sys == `SRC_EXT_OSC) begin
      if (!sel[0])
        src_count = startup_time_select[1] ? CNT_RES_L : CNT_RES_S;
      else
        src_count = (startup_time_select == 2'h0) ? CNT_RES_L : CNT_XTAL;
    end
    if (!from_reset && src_count == CNT_ZERO)
      src_count = CNT_RC;
  end

  always @* begin
    case (dec_sys)
      `SRC_EXT_CLOCK: src_ready = i_ext_clock_ready;
      `SRC_RC_OSC: src_ready = i_rc_ready;
      `SRC_EXT_OSC: src_ready = i_ext_osc_ready;
      default: src_ready = i_pll_lock;
    endcase
  end

  // ==========================================
  // Counters: one on the watchdog oscillator, one on the selected source
  delay_counter u_wdt_cnt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_load(wdt_load),
    .i_count(wdt_count),
    .i_tick(i_wdt_tick),
    .o_done(wdt_done)
  );

  delay_counter u_src_cnt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_load(src_load),
    .i_count(src_load_count),
    .i_tick(i_src_tick),
    .o_done(src_done)
  );

  // ==========================================
  // Sequencer
  always @* begin
    next_state = state;
    wdt_load = 1'b0;
    src_load = 1'b0;
    case (state)
      ST_LATCH: begin
        next_state = ST_RST_DLY;
        wdt_load = 1'b1;
      end
      ST_RST_DLY: begin
        if (dec_invalid)
          next_state = ST_FAULT;
        else if (wdt_done) begin
          next_state = ST_SWITCH;
          src_load = 1'b1;
        end
      end
      ST_SWITCH: begin
        if (src_done) begin
          next_state = ST_START;
          src_load = 1'b1;
        end
      end
      ST_START: begin
        if (src_done && src_ready)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (i_power_down)
          next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (i_async_wake) begin
          next_state = ST_START;
          src_load = 1'b1;
        end
      end
      ST_FAULT: next_state = ST_FAULT;
      default: next_state = ST_LATCH;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_LATCH;
      from_reset <= 1'b1;
    end else if (i_ce) begin
      state <= next_state;
      if (state == ST_SLEEP)
        from_reset <= 1'b0;
    end
  end

  // ==========================================
  // Domain enables, worked out one cycle ahead so they rise as the state enters run
  always @* begin
    next_run = (next_state == ST_RUN);
    next_core_en = next_run && !i_stop_core;
    next_peripheral_en = next_run && !i_stop_peripheral;
    // Converter keeps running in sleep so conversions see less digital noise
    next_converter_en = (next_run || next_state == ST_SLEEP) && !i_stop_converter;
    next_pll_enable = pll_used && state != ST_SLEEP && state != ST_FAULT &&
                      state != ST_LATCH;
    next_pll_clock_en = next_run && pll_used && i_pll_lock;
  end

  // ==========================================
  // Source mux; it only moves while every domain is gated, so no runt edges
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_sys_src <= `SRC_RC_OSC;
      o_pll_src <= `SRC_RC_OSC;
    end else if (i_ce && state == ST_SWITCH) begin
      o_sys_src <= dec_sys;
      o_pll_src <= dec_pll;
    end
  end

  // ==========================================
  // Registered outputs
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_pll_enable <= 1'b0;
      o_fast_64 <= 1'b0;
      o_div8_active <= 1'b0;
      o_cfg_invalid <= 1'b0;
      o_core_clock_en <= 1'b0;
      o_peripheral_clock_en <= 1'b0;
      o_program_memory_clock_en <= 1'b0;
      o_converter_clock_en <= 1'b0;
      o_fast_multiplied_clock_en <= 1'b0;
      o_cpu_run <= 1'b0;
    end else if (i_ce) begin
      o_div8_active <= ~div8_stored;
      o_cfg_invalid <= dec_invalid && state != ST_LATCH;
      o_fast_64 <= i_fast_64;
      o_pll_enable <= next_pll_enable;
      o_fast_multiplied_clock_en <= next_pll_clock_en;
      o_cpu_run <= next_core_en;
      o_core_clock_en <= next_core_en;
      o_program_memory_clock_en <= next_core_en;
      o_peripheral_clock_en <= next_peripheral_en;
      o_converter_clock_en <= next_converter_en;
    end
  end

endmodule

// >>> tb/source_control_monitor.sv
// Concurrent checks on the clock source controller ports
`timescale 1ns/1ps
module source_control_monitor (
  input logic i_clk,
  input logic i_rst,
  input logic i_ce,
  input logic i_stop_core,
  input logic i_stop_peripheral,
  input logic i_stop_converter,
  input logic i_power_down,
  input logic [1:0] o_sys_src,
  input logic o_cfg_invalid,
  input logic o_core_clock_en,
  input logic o_peripheral_clock_en,
  input logic o_program_memory_clock_en,
  input logic o_converter_clock_en,
  input logic o_cpu_run
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================
  // Domain gating
  property p_flash_follows; o_program_memory_clock_en == o_core_clock_en; endproperty
  a_flash_follows: assert property (p_flash_follows)
    else $error("program memory clock differs from core clock");
  property p_core_stop; i_ce && i_stop_core |=> !o_core_clock_en; endproperty
  a_core_stop: assert property (p_core_stop)
    else $error("core clock runs while stopped");
  property p_io_stop; i_ce && i_stop_peripheral |=> !o_peripheral_clock_en; endproperty
  a_io_stop: assert property (p_io_stop)
    else $error("peripheral clock runs while stopped");
  property p_adc_stop; i_ce && i_stop_converter |=> !o_converter_clock_en; endproperty
  a_adc_stop: assert property (p_adc_stop)
    else $error("converter clock runs while stopped");
  // Converter keeps going in sleep so conversions stay quiet
  property p_sleep;
    i_ce && o_cpu_run && i_power_down && !i_stop_converter |=>
      !o_cpu_run && !o_core_clock_en && o_converter_clock_en;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep entry gated the wrong domains");
  // ==========================================
  // Start-up and configuration
  property p_run_enables; $rose(o_cpu_run) |-> o_core_clock_en == !$past(i_stop_core); endproperty
  a_run_enables: assert property (p_run_enables)
    else $error("core clock not enabled with run");
  property p_invalid_gates;
    o_cfg_invalid |-> !(o_core_clock_en || o_peripheral_clock_en ||
                        o_converter_clock_en || o_cpu_run);
  endproperty
  a_invalid_gates: assert property (p_invalid_gates)
    else $error("clocks enabled with invalid selection");
  property p_invalid_holds; o_cfg_invalid |=> o_cfg_invalid; endproperty
  a_invalid_holds: assert property (p_invalid_holds)
    else $error("invalid selection cleared without reset");
  property p_src_steady; o_cpu_run && $past(o_cpu_run) |-> $stable(o_sys_src); endproperty
  a_src_steady: assert property (p_src_steady)
    else $error("system source changed while running");
endmodule
bind clock_source_control source_control_monitor u_mon (.*);

// >>> tb/osc_model.sv
// Behavioural oscillators, PLL and watchdog oscillator facing the controller
`timescale 1ns/1ps
module osc_model (
  input logic i_clk,
  input logic i_rst,
  input logic i_slow,
  output logic o_wdt_tick,
  output logic o_src_tick,
  output logic o_ext_clock_ready,
  output logic o_rc_ready,
  output logic o_ext_osc_ready,
  output logic o_pll_lock
);
  int cnt;
  always @(posedge i_clk) begin
    if (i_rst) cnt <= 0;
    else cnt <= cnt + 1;
  end
  // Slow mode makes sources settle late so the controller must wait on ready
  assign o_wdt_tick = cnt[0];
  assign o_src_tick = i_slow ? (cnt % 3 == 0) : 1'b1;
  assign o_ext_clock_ready = cnt > (i_slow ? 250 : 20);
  assign o_rc_ready = cnt > (i_slow ? 200 : 10);
  assign o_ext_osc_ready = cnt > (i_slow ? 300 : 30);
  assign o_pll_lock = cnt > (i_slow ? 320 : 40);
endmodule

// >>> tb/clock_source_control_tb.sv
// Self-checking bench for the clock source controller
`timescale 1ns/1ps
module clock_source_control_tb;
  logic i_clk = 0, i_rst = 1, later = 0, prog = 1, d8 = 1, slow = 0, i_async_wake = 0;
  logic ce = 1, fast = 0, pu, lock_q, o_pll_enable, o_fast_64, o_fast_multiplied_clock_en;
  logic i_power_down = 0, i_stop_core = 0, i_stop_peripheral = 0, i_stop_converter = 0;
  logic [3:0] sel = 0;
  logic [1:0] startup_time_select = 0, o_sys_src, o_pll_src;
  logic wdt, src, r_clk, r_rc, r_osc, lock, o_div8_active, o_cfg_invalid, o_cpu_run;
  logic o_core_clock_en, o_peripheral_clock_en, o_program_memory_clock_en, o_converter_clock_en;
  int err_count = 0, checks_done = 0, seed = 87, wcnt, n, r;
  logic [4:0] e;
  always #50 i_clk = ~i_clk;
  clock_source_control #(.WDT_TIMEOUT(15'h0010), .XTAL_START(15'h0020)) u_clock_source_control (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_later_variant(later),
    .i_fuse_programmed(prog), .i_clock_source_select_field(sel),
    .i_startup_time_select(startup_time_select), .i_divide_by_eight_option(d8), .i_fast_64(fast),
    .i_wdt_tick(wdt), .i_src_tick(src), .i_ext_clock_ready(r_clk), .i_rc_ready(r_rc),
    .i_ext_osc_ready(r_osc), .i_pll_lock(lock), .i_power_down(i_power_down),
    .i_stop_core(i_stop_core), .i_stop_peripheral(i_stop_peripheral),
    .i_stop_converter(i_stop_converter), .i_async_wake(i_async_wake),
    .o_sys_src(o_sys_src), .o_pll_src(o_pll_src), .o_pll_enable(o_pll_enable),
    .o_fast_64(o_fast_64),
    .o_div8_active(o_div8_active), .o_cfg_invalid(o_cfg_invalid),
    .o_core_clock_en(o_core_clock_en), .o_peripheral_clock_en(o_peripheral_clock_en),
    .o_program_memory_clock_en(o_program_memory_clock_en),
    .o_converter_clock_en(o_converter_clock_en),
    .o_fast_multiplied_clock_en(o_fast_multiplied_clock_en),
    .o_cpu_run(o_cpu_run));
  osc_model u_osc_model (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .o_wdt_tick(wdt),
    .o_src_tick(src), .o_ext_clock_ready(r_clk), .o_rc_ready(r_rc),
    .o_ext_osc_ready(r_osc), .o_pll_lock(lock));
  // Watchdog ticks seen since reset while the core is not running
  always @(posedge i_clk) begin
    if (i_rst) wcnt <= 0;
    else if (wdt && o_cpu_run !== 1'b1) wcnt <= wcnt + 1;
  end
  // PLL lock as the design saw it at the last rising edge
  always @(posedge i_clk) lock_q <= lock;
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Packs {invalid, system source, PLL input}
  function automatic logic [4:0] exp_map(input logic l, input logic [3:0] s);
    if (s[3]) return 5'h09;
    case ({l, s[2:0]})
      4'h0, 4'h8: return 5'h01;
      4'h2, 4'ha: return 5'h05;
      4'h3, 4'hb: return 5'h0d;
      4'h9: return 5'h0c;
      4'hc: return 5'h0a;
      4'hd: return 5'h0e;
      default: return 5'h10;
    endcase
  endfunction
  task boot(input logic l, input logic [3:0] s, input logic p);
    @(negedge i_clk);
    r = $random(seed);
    {later, sel, prog, startup_time_select, d8, slow, fast} = {l, s, p, r[0], 1'b0, r[1], r[2], r[3]};
    ce = 1;
    i_rst = 1;
    repeat (12) @(negedge i_clk);
    i_rst = 0;
    n = 0;
    while (o_cpu_run !== 1'b1 && o_cfg_invalid !== 1'b1 && n < 8000) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  initial begin
    for (int v = 0; v < 2; v++) for (int c = 0; c < 16; c++) begin
      boot(v[0], c[3:0], 1'b1);
      e = exp_map(v[0], c[3:0]);
      check("invalid", o_cfg_invalid, e[4]);
      check("run", o_cpu_run, !e[4]);
      if (!e[4]) begin
        check("sys", o_sys_src, e[3:2]);
        if (v) check("pll", o_pll_src, e[1:0]);
        check("div8", o_div8_active, !d8);
        check("rst delay", wcnt >= (startup_time_select[1] ? 16 : 14), 1);
        pu = e[3:2] == 2'h3 || e[1:0] != 2'h1 || fast;
        check("fast64", o_fast_64, fast);
        check("pll en", o_pll_enable, pu);
        check("pll clk", o_fast_multiplied_clock_en, pu && lock_q);
      end
    end
    boot(1'b1, 4'hf, 1'b0);
    check("dflt sys", o_sys_src, 1);
    check("dflt div8", o_div8_active, 1);
    i_power_down = 1;
    repeat (2) @(negedge i_clk);
    i_power_down = 0;
    check("sleep run", o_cpu_run, 0);
    check("sleep io", o_peripheral_clock_en, 0);
    check("sleep adc", o_converter_clock_en, 1);
    i_async_wake = 1;
    n = 0;
    while (o_cpu_run !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    i_async_wake = 0;
    check("wake time", n < 30, 1);
    ce = 0;
    i_power_down = 1;
    repeat (3) @(negedge i_clk);
    check("ce hold", o_cpu_run, 1);
    ce = 1;
    i_power_down = 0;
    repeat (300) begin
      @(negedge i_clk);
      r = $random(seed);
      {i_stop_core, i_stop_peripheral, i_stop_converter} = r[2:0];
      i_power_down = r[7:3] == 0;
      i_async_wake = r[12:8] == 0;
      ce = r[13] | r[14];
    end
    stop_test;
  end
  // A hang is cut off well past the longest expected run
  initial begin
    #8000000;
    err_count++;
    stop_test;
  end
endmodule
